// File: pkg/fra_pkg.sv
/*
  package for the floating-point register access block: format codes,
  condition-code bit positions and reset values.
  assumes a single core clock and a pipeline that drives format codes
  from this enumeration.
*/
package fra_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int FRA_WORD_W = 32;          // one register word
  localparam int FRA_REG_COUNT = 32;       // registers in the file
  localparam int FRA_IDX_W = 5;            // register number width
  localparam int FRA_SEL_W = 3;            // condition select width
  localparam int FRA_CC_COUNT = 8;         // condition codes 0..7

  // ----------------------------------------------------------------
  // condition bit placement in the control/status register
  // ----------------------------------------------------------------
  localparam int FRA_CC0_BIT = 23;         // code 0 position
  localparam int FRA_CCN_BASE = 24;        // code n sits at base + n

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FRA_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] FRA_CSR_RESET = 32'h0000_0000;
  localparam logic [63:0] FRA_UNPRED_VALUE = 64'h0000_0000_0000_0000;

  // access formats seen on the format port
  typedef enum logic [2:0] {
    FRA_FMT_SINGLE,
    FRA_FMT_DOUBLE,
    FRA_FMT_WORD,
    FRA_FMT_PAIRED_BYTE,   // paired_byte_format
    FRA_FMT_QUAD_HALF,     // quad_half_format
    FRA_FMT_RAW_WORD,
    FRA_FMT_RAW_DOUBLE
  } fra_fmt_t;
endpackage : fra_pkg

// File: design/fra_cond_bits.sv
/*
  condition-code block: holds the floating-point control/status register
  and reads or replaces one of its eight condition bits.
  assumes the pipeline gives one condition select per cycle.
*/
`timescale 1ns/10ps
module fra_cond_bits
  import fra_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [FRA_SEL_W-1:0] condition_select_in,  // code number
  input wire logic condition_bit_write_in,               // write strobe
  input wire logic condition_value_in,                   // new bit
  input wire logic csr_load_in,                          // whole-word load
  input wire logic [FRA_WORD_W-1:0] csr_data_in,         // whole-word data
  output logic condition_bit_read_out,                   // selected bit
  output logic [FRA_WORD_W-1:0] fp_control_status_reg_out // register value
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [FRA_WORD_W-1:0] csr;       // control/status register
  logic [FRA_WORD_W-1:0] next_csr;  // its next value
  logic [4:0] bit_pos;              // mapped bit position, 23 or 25..31

  // code 0 lives apart from codes 1..7, which skip bit 24
  always_comb
  begin
    if (condition_select_in == '0)
    begin
      bit_pos = 5'(FRA_CC0_BIT);
    end
    else
    begin
      // widest sum is 24 + 7, so five bits never wrap
      bit_pos = 5'(FRA_CCN_BASE) + 5'(condition_select_in);
    end
  end

  // replace only the mapped bit; a whole-word load loses to it
  always_comb
  begin
    next_csr = csr;
    if (csr_load_in)
    begin
      next_csr = csr_data_in;
    end
    if (condition_bit_write_in)
    begin
      next_csr[bit_pos] = condition_value_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      csr <= FRA_CSR_RESET;
    end
    else
    begin
      csr <= next_csr;
    end
  end

  // the read is combinational from the stored register
  assign condition_bit_read_out = csr[bit_pos];
  assign fp_control_status_reg_out = csr;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  cc_write_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (condition_bit_write_in && !csr_load_in) |=>
      ((csr ^ $past(csr)) & ~(32'h0000_0001 << $past(bit_pos))) == '0)
    else $error("condition write disturbed other bits");

  cc_write_lands_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    condition_bit_write_in |=> csr[$past(bit_pos)] == $past(condition_value_in))
    else $error("condition bit not written");

  cc_zero_map_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (condition_select_in == 3'h0) |-> condition_bit_read_out == csr[23])
    else $error("code 0 not at bit 23");

  cc_n_map_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (condition_select_in != 3'h0) |->
      condition_bit_read_out == csr[24 + int'(condition_select_in)])
    else $error("code n not at bit 24+n");

  cc_bit24_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!csr_load_in) |=> csr[24] == $past(csr[24]))
    else $error("bit 24 touched by a condition write");

  cc_write_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    condition_bit_write_in && condition_select_in == 3'h7);
endmodule : fra_cond_bits

// File: design/fra_register_access.sv
/*
  floating-point register file with format-dependent access and the
  condition-code block beneath it.
  assumes the pipeline drives number, format and data synchronously and
  never relies on reading a value in a format other than its written one.
*/
`timescale 1ns/10ps
// Function
// - single/word/raw-word read returns register unchanged
// - even double read returns upper odd, lower even
// - odd-base doubleword access is unpredictable
// - other formats read an unpredictable value
// - word writes one register, double writes pair
// - stored encoding is exactly what reads back
// - no cross-format conversion; issuer must not rely
// - loads and stores use raw formats, same placement
// - code 0 is bit 23, code n bit 24+n
// - condition write replaces only its mapped bit
module fra_register_access
  import fra_pkg::*;
#(
  parameter int REG_COUNT = FRA_REG_COUNT,  // registers in the file
  parameter int WORD_W = FRA_WORD_W         // bits per register
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  // read side
  input wire logic [FRA_IDX_W-1:0] read_index_in,       // register number
  input wire fra_fmt_t read_format_in,                  // access format
  output logic [2*WORD_W-1:0] formatted_register_read_out, // read value
  output logic read_unpredictable_out,                  // value undefined
  // write side
  input wire logic formatted_register_write_in,         // write strobe
  input wire logic [FRA_IDX_W-1:0] write_index_in,      // register number
  input wire fra_fmt_t write_format_in,                 // access format
  input wire logic [2*WORD_W-1:0] write_data_in,        // low word first
  output logic write_ignored_out,                       // write dropped
  // condition codes
  input wire logic [FRA_SEL_W-1:0] condition_select_in,
  input wire logic condition_bit_write_in,
  input wire logic condition_value_in,
  input wire logic csr_load_in,
  input wire logic [FRA_WORD_W-1:0] csr_data_in,
  output logic condition_bit_read_out,
  output logic [FRA_WORD_W-1:0] fp_control_status_reg_out
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] regs [REG_COUNT];       // register array
  logic [WORD_W-1:0] next_regs [REG_COUNT];  // next array values
  logic wr_single;                           // one-word write
  logic wr_pair;                             // legal pair write
  logic rd_single;                           // one-word read
  logic rd_pair;                             // legal pair read
  logic [FRA_IDX_W-1:0] rd_odd_index;        // partner of read base

  // decode formats; raw formats share placement with word/double
  always_comb
  begin
    wr_single = write_format_in inside {FRA_FMT_SINGLE, FRA_FMT_WORD,
                                        FRA_FMT_RAW_WORD};
    wr_pair = (write_format_in inside {FRA_FMT_DOUBLE, FRA_FMT_RAW_DOUBLE})
              && !write_index_in[0];
    rd_single = read_format_in inside {FRA_FMT_SINGLE, FRA_FMT_WORD,
                                       FRA_FMT_RAW_WORD};
    rd_pair = (read_format_in inside {FRA_FMT_DOUBLE, FRA_FMT_RAW_DOUBLE})
              && !read_index_in[0];
    rd_odd_index = read_index_in | 5'h01;
  end

  // ----------------------------------------------------------------
  // write port: one per cycle, pairs update two entries
  // ----------------------------------------------------------------
  // an odd base or packed format stores nothing, keeping state safe
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_entry
    always_comb
    begin
      next_regs[i] = regs[i];
      if (formatted_register_write_in && wr_single &&
          write_index_in == FRA_IDX_W'(i))
      begin
        next_regs[i] = write_data_in[WORD_W-1:0];
      end
      else if (formatted_register_write_in && wr_pair &&
               write_index_in == FRA_IDX_W'(i & ~1))
      begin
        // low half to the even entry, high half to the odd one
        next_regs[i] = (i % 2 == 0) ? write_data_in[WORD_W-1:0]
                                    : write_data_in[2*WORD_W-1:WORD_W];
      end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        regs[i] <= FRA_REG_RESET;
      end
      else
      begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path: raw bits returned, no conversion anywhere
  // ----------------------------------------------------------------
  // combinational so a read sees the last stored encoding directly
  always_comb
  begin
    formatted_register_read_out = FRA_UNPRED_VALUE;
    read_unpredictable_out = 1'b1;
    if (rd_single)
    begin
      formatted_register_read_out = {{WORD_W{1'b0}}, regs[read_index_in]};
      read_unpredictable_out = 1'b0;
    end
    else if (rd_pair)
    begin
      formatted_register_read_out = {regs[rd_odd_index], regs[read_index_in]};
      read_unpredictable_out = 1'b0;
    end
  end
  // the issuer owns format consistency; bits pass untouched

  assign write_ignored_out = formatted_register_write_in && !wr_single && !wr_pair;

  // ----------------------------------------------------------------
  // condition codes
  // ----------------------------------------------------------------
  fra_cond_bits u_cond (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .condition_select_in(condition_select_in),
    .condition_bit_write_in(condition_bit_write_in),
    .condition_value_in(condition_value_in),
    .csr_load_in(csr_load_in),
    .csr_data_in(csr_data_in),
    .condition_bit_read_out(condition_bit_read_out),
    .fp_control_status_reg_out(fp_control_status_reg_out)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wr_back_word_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (formatted_register_write_in && wr_single) |=>
      regs[$past(write_index_in)] == $past(write_data_in[WORD_W-1:0]))
    else $error("word write not stored");

  wr_pair_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (formatted_register_write_in && wr_pair) |=>
      regs[$past(write_index_in)] == $past(write_data_in[WORD_W-1:0]))
    else $error("pair low half misplaced");

  wr_pair_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (formatted_register_write_in && wr_pair) |=>
      regs[$past(write_index_in) | 5'h01] == $past(write_data_in[2*WORD_W-1:WORD_W]))
    else $error("pair high half misplaced");

  rd_word_raw_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_single |-> formatted_register_read_out[WORD_W-1:0] == regs[read_index_in]
                  && !read_unpredictable_out)
    else $error("word read altered");

  rd_pair_order_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_pair |-> formatted_register_read_out ==
                {regs[read_index_in | 5'h01], regs[read_index_in]})
    else $error("pair read order wrong");

  odd_base_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (read_format_in inside {FRA_FMT_DOUBLE, FRA_FMT_RAW_DOUBLE} && read_index_in[0]) |->
      read_unpredictable_out)
    else $error("odd pair base not flagged");

  odd_write_kept_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (formatted_register_write_in && !wr_single && !wr_pair) |=>
      regs[$past(write_index_in)] == $past(regs[write_index_in]))
    else $error("illegal write changed state");

  packed_fmt_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (read_format_in inside {FRA_FMT_PAIRED_BYTE, FRA_FMT_QUAD_HALF}) |->
      read_unpredictable_out)
    else $error("packed format read not flagged");

  wr_pair_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    formatted_register_write_in && wr_pair ##1 rd_pair);
  wr_word_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    formatted_register_write_in && write_format_in == FRA_FMT_RAW_WORD);
  odd_read_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    read_format_in == FRA_FMT_RAW_DOUBLE && read_index_in[0]);
endmodule : fra_register_access

// File: tb/fra_pipe_model.sv
/*
  pipeline-side model: issues register writes, condition-code writes
  and whole status loads to the register access block.
  assumes one clock and drives 1 ns after each rising edge.
*/
`timescale 1ns/10ps
module fra_pipe_model
  import fra_pkg::*;
(
  input wire logic clk_in,
  output logic wr_out,               // write strobe
  output logic [4:0] idx_out,        // write register number
  output fra_fmt_t fmt_out,          // write format
  output logic [63:0] data_out,      // write data, low word first
  output logic [2:0] sel_out,        // condition select
  output logic cc_wr_out,            // condition write strobe
  output logic cc_val_out,           // new condition bit
  output logic ld_out,               // whole status load
  output logic [31:0] ld_data_out    // whole status data
);
  // ----------------------------------------------------------------
  // idle values at time zero
  // ----------------------------------------------------------------
  initial
  begin
    {wr_out, cc_wr_out, cc_val_out, ld_out} = 4'h0;
    {idx_out, sel_out} = 8'h00;
    fmt_out = FRA_FMT_WORD;
    data_out = 64'h0;
    ld_data_out = 32'h0;
  end

  // one write a cycle; reads are driven by the bench, not by this model
  task write_reg(input logic [4:0] i, input fra_fmt_t f, input logic [63:0] d);
    @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    idx_out = i;
    fmt_out = f;
    data_out = d;
  endtask : write_reg

  task write_cc(input logic [2:0] s, input logic v);
    @(posedge clk_in);
    #1;
    sel_out = s;
    cc_wr_out = 1'b1;
    cc_val_out = v;
  endtask : write_cc

  task load_csr(input logic [31:0] d);
    @(posedge clk_in);
    #1;
    ld_out = 1'b1;
    ld_data_out = d;
  endtask : load_csr

  // released data is inverted so a stale value never passes for a match
  task idle;
    @(posedge clk_in);
    #1;
    {wr_out, cc_wr_out, ld_out} = 3'h0;
    data_out = ~data_out;
    ld_data_out = ~ld_data_out;
  endtask : idle
endmodule : fra_pipe_model

// File: tb/fra_register_access_test.sv
/*
  self-checking bench for the register access block: word and pair
  accesses, refused accesses and the eight condition bits.
  assumes the pipeline model above drives all write-side inputs.
*/
`timescale 1ns/10ps
module fra_register_access_test;
  import fra_pkg::*;
  logic clk_in;
  logic rst_n_in;
  logic [4:0] rd_idx;           // read number, bench driven
  fra_fmt_t rd_fmt;             // read format, bench driven
  logic [63:0] rd_data;
  logic rd_unpred;
  logic wr_ign;
  logic cc_bit;
  logic [31:0] csr;
  logic wr_stb, cc_wr, cc_val, csr_ld;
  logic [4:0] wr_idx;
  fra_fmt_t wr_fmt;
  logic [63:0] wr_data;
  logic [2:0] cc_sel;
  logic [31:0] csr_dat;
  logic [31:0] exp_csr;
  int err_count = 0;
  int total_checks = 0;
  int b;
  fra_fmt_t word_fmts [3] = '{FRA_FMT_SINGLE, FRA_FMT_WORD, FRA_FMT_RAW_WORD};

  // ----------------------------------------------------------------
  // design, pipeline model, clock
  // ----------------------------------------------------------------
  fra_register_access dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .read_index_in(rd_idx), .read_format_in(rd_fmt),
    .formatted_register_read_out(rd_data), .read_unpredictable_out(rd_unpred),
    .formatted_register_write_in(wr_stb), .write_index_in(wr_idx),
    .write_format_in(wr_fmt), .write_data_in(wr_data), .write_ignored_out(wr_ign),
    .condition_select_in(cc_sel), .condition_bit_write_in(cc_wr),
    .condition_value_in(cc_val), .csr_load_in(csr_ld), .csr_data_in(csr_dat),
    .condition_bit_read_out(cc_bit), .fp_control_status_reg_out(csr));
  fra_pipe_model pipe_u (.clk_in(clk_in), .wr_out(wr_stb), .idx_out(wr_idx),
    .fmt_out(wr_fmt), .data_out(wr_data), .sel_out(cc_sel), .cc_wr_out(cc_wr),
    .cc_val_out(cc_val), .ld_out(csr_ld), .ld_data_out(csr_dat));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // shared checks
  // ----------------------------------------------------------------
  task check(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  // reads are combinational, so sample 1 ns after driving
  task read_check(input logic [4:0] i, input fra_fmt_t f, input logic [63:0] e,
                  input logic u);
    @(posedge clk_in);
    #1;
    rd_idx = i;
    rd_fmt = f;
    #1;
    check(rd_data, e, "read data");
    check(rd_unpred, u, "unpredictable flag");
  endtask : read_check

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // watchdog; the run itself is about 80 cycles
  initial
  begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    rd_idx = 5'h00;
    rd_fmt = FRA_FMT_WORD;
    repeat (10) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    read_check(5'h1e, FRA_FMT_DOUBLE, 64'h0, 1'b0);
    check(csr, 64'h0, "status after reset");
    $display("test reset done");
    // back-to-back word writes; upper data half must be dropped
    for (int i = 0; i < 3; i++)
    begin
      pipe_u.write_reg(i[4:0], word_fmts[i], {32'hffff_ffff, 32'h1357_9bd0 + i});
      #1;
      check(wr_ign, 64'h0, "legal write ignored");
    end
    pipe_u.idle();
    for (int i = 0; i < 3; i++)
    begin
      read_check(i[4:0], word_fmts[i], {32'h0, 32'h1357_9bd0 + i}, 1'b0);
      read_check(i[4:0], FRA_FMT_RAW_WORD, {32'h0, 32'h1357_9bd0 + i}, 1'b0);
    end
    $display("test word done");
    pipe_u.write_reg(5'h04, FRA_FMT_DOUBLE, 64'h89ab_cdef_0123_4567);
    pipe_u.write_reg(5'h06, FRA_FMT_RAW_DOUBLE, 64'h0f1e_2d3c_4b5a_6978);
    pipe_u.idle();
    read_check(5'h04, FRA_FMT_DOUBLE, 64'h89ab_cdef_0123_4567, 1'b0);
    // halves of a pair are only read back uninterpreted, never as words
    read_check(5'h05, FRA_FMT_RAW_WORD, 64'h89ab_cdef, 1'b0);
    read_check(5'h06, FRA_FMT_RAW_DOUBLE, 64'h0f1e_2d3c_4b5a_6978, 1'b0);
    read_check(5'h06, FRA_FMT_RAW_WORD, 64'h4b5a_6978, 1'b0);
    $display("test double done");
    pipe_u.write_reg(5'h05, FRA_FMT_DOUBLE, 64'h1111_2222_3333_4444);
    #1;
    check(wr_ign, 64'h1, "odd pair write");
    pipe_u.write_reg(5'h01, FRA_FMT_PAIRED_BYTE, 64'h5555_6666_7777_8888);
    #1;
    check(wr_ign, 64'h1, "paired byte write");
    pipe_u.write_reg(5'h02, FRA_FMT_QUAD_HALF, 64'h5555_6666_7777_8888);
    #1;
    check(wr_ign, 64'h1, "quad half write");
    pipe_u.idle();
    read_check(5'h05, FRA_FMT_RAW_WORD, 64'h89ab_cdef, 1'b0);
    read_check(5'h06, FRA_FMT_RAW_WORD, 64'h4b5a_6978, 1'b0);
    read_check(5'h01, FRA_FMT_WORD, 64'h1357_9bd1, 1'b0);
    read_check(5'h02, FRA_FMT_RAW_WORD, 64'h1357_9bd2, 1'b0);
    read_check(5'h05, FRA_FMT_DOUBLE, FRA_UNPRED_VALUE, 1'b1);
    read_check(5'h03, FRA_FMT_RAW_DOUBLE, FRA_UNPRED_VALUE, 1'b1);
    read_check(5'h00, FRA_FMT_PAIRED_BYTE, FRA_UNPRED_VALUE, 1'b1);
    read_check(5'h00, FRA_FMT_QUAD_HALF, FRA_UNPRED_VALUE, 1'b1);
    read_check(5'h00, fra_fmt_t'(3'h7), FRA_UNPRED_VALUE, 1'b1);
    $display("test refused done");
    exp_csr = 32'ha5a5_5a5a;
    pipe_u.load_csr(exp_csr);
    pipe_u.idle();
    #1;
    check(csr, exp_csr, "status after load");
    // each code flipped twice so both values land in every bit
    for (int k = 0; k < 16; k++)
    begin
      b = (k % 8 == 0) ? 23 : 24 + k % 8;
      pipe_u.write_cc(3'(k % 8), ~exp_csr[b]);
      pipe_u.idle();
      exp_csr[b] = ~exp_csr[b];
      #1;
      check(csr, exp_csr, "status after code write");
      check(cc_bit, exp_csr[b], "condition bit read");
    end
    // load left high while a code write arrives: the code bit wins
    pipe_u.load_csr(32'h0f0f_f0f0);
    pipe_u.write_cc(3'h3, 1'b0);
    pipe_u.idle();
    #1;
    check(csr, 32'h070f_f0f0, "code write over load");
    check(cc_bit, 64'h0, "code 3 after load");
    $display("test condition done");
    // reset again mid-run; every register and the status word clear
    @(posedge clk_in);
    #1;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    read_check(5'h04, FRA_FMT_DOUBLE, 64'h0, 1'b0);
    check(csr, 64'h0, "status after second reset");
    check(cc_bit, 64'h0, "code 3 after second reset");
    $display("test second reset done");
    print_verdict();
  end
endmodule : fra_register_access_test
